/* hdl/sbc_pkg.sv */
// constants and types for the sensorless commutation block
package sbc_pkg;
  // the resonator is the block clock
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int RES_FREQ_HZ = 25_000_000;
  localparam int CHECK_PERIODS = 512;
  localparam int CHECK_CYCLES = CHECK_PERIODS * (CLK_FREQ_HZ / RES_FREQ_HZ);
  localparam int WIN_W = 9;
  localparam logic [WIN_W-1:0] CHECK_LAST = WIN_W'(CHECK_CYCLES - 1);
  localparam int FST_CNT_BITS = 14;
  localparam int FST_EXP = FST_CNT_BITS + 3;
  localparam int STEPS_PER_TURN = 6;
  // start frequency is res/(6*2^exp); one of six steps lasts 2^exp periods
  localparam int FST_STEP_PERIODS = (STEPS_PER_TURN * (1 << FST_EXP)) / STEPS_PER_TURN;
  localparam int FST_STEP_CYCLES = FST_STEP_PERIODS * (CLK_FREQ_HZ / RES_FREQ_HZ);
  localparam int TMR_W = 20;
  localparam logic [TMR_W-1:0] TMR_MAX = {TMR_W{1'b1}};
  localparam logic [TMR_W-1:0] TMR_ZERO = '0;
  localparam logic [1:0] ZC_TO_NORMAL = 2'h2;
  localparam logic [2:0] STEP_FIRST = 3'h0;
  localparam logic [2:0] STEP_LAST = 3'h5;
  localparam int PH_U = 0;
  localparam int PH_V = 1;
  localparam int PH_W = 2;
  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h8;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LEAD_0 = 2'h0, LEAD_7P5 = 2'h1, LEAD_15 = 2'h2, LEAD_30 = 2'h3} sbc_lead_t;
  typedef enum logic [1:0] {ST_STOP = 2'h0, ST_FORCED = 2'h1, ST_NORMAL = 2'h2} sbc_state_t;
  typedef enum logic [1:0] {SEL_CTRL = 2'h0, SEL_STATUS = 2'h1, SEL_PERIOD = 2'h2, SEL_NONE = 2'h3} sbc_sel_t;
  // control register, msb first: lap120 alt_form rev_dir advance_sel_bit1 advance_sel_bit0
  typedef struct packed {logic lap120; logic alt; logic rev; logic [1:0] adv;} sbc_cfg_t;
  // phase masks, bit index is PH_U/PH_V/PH_W
  typedef struct packed {logic [2:0] hi; logic [2:0] lo;} sbc_drive_t;
  typedef struct packed {logic [2:0] hi_n; logic [2:0] lo;} sbc_pins_t;
  localparam sbc_pins_t PINS_OFF = '{hi_n: 3'h7, lo: 3'h0};
  typedef struct packed {logic [1:0] lead; logic oc; logic [2:0] step; logic normal; logic run;} sbc_status_t;
endpackage

/* hdl/sbc_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sbc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  wire [W-1:0] differ = s2_reg ^ s3_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      out_reg <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a change counts only once stages two and three agree
      out_reg <= (~differ & s2_reg) | (differ & out_reg);
    end
  end

  assign dout = out_reg;
endmodule

/* hdl/sbc_top.sv */
// sensorless three-phase commutation logic with AXI4-Lite control
//
// Behaviour
// RQ1 - upper switch outputs are low for on, high for off.
// RQ2 - lower switch outputs are high for on, low for off.
// RQ3 - one position input carries the majority of the three terminal voltages.
// RQ4 - after start, step forced patterns regardless of rotor position.
// RQ5 - valid position edges end forced stepping; back-EMF then times commutation.
// RQ6 - forced step rate is resonator over six times two to seventeen.
// RQ7 - external PWM gates the turn-on outputs.
// RQ8 - position is sampled only on PWM rising edges.
// RQ9 - PWM source runs well above electrical frequency, suited to power stage.
// RQ10 - position change confirmed by two consecutive PWM rising edge samples.
// RQ11 - output form select picks one of two PWM forms.
// RQ12 - over-current rise cuts the chopped switch until next PWM pulse.
// RQ13 - lead angle zero while forced, selected lead once normal.
// RQ14 - both lead bits high gives thirty degrees in forced mode too.
// RQ15 - lap select high gives plain 120 degree conduction.
// RQ16 - lap select low stretches turn-on for overlap, lead dependent.
// RQ17 - zero PWM duty is recognised as stop.
// RQ18 - an applied PWM on-level is recognised as start.
// RQ19 - start/stop checked every 512 periods, acting on two agreeing checks.
// RQ20 - lead pair codes 0, 7.5, 15 and 30 degrees.
// RQ21 - form low chops upper only; high alternates upper and lower.
// RQ22 - direction high runs U, W, V; low runs U, V, W.
// RQ23 - PWM input is active low; source never holds it low permanently.
// RQ24 - while stopped all outputs off and state back to forced start.
`timescale 1ns/1ps
module sbc_top #(
  parameter int FORCE_STEP_CYCLES = sbc_pkg::FST_STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sbc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sbc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_n_in,
  input wire logic position_in,
  input wire logic overcurrent_in,
  output logic u_high_side_on_n,
  output logic u_low_side_on,
  output logic v_high_side_on_n,
  output logic v_low_side_on,
  output logic w_high_side_on_n,
  output logic w_low_side_on
);
  localparam logic [sbc_pkg::TMR_W-1:0] FORCE_LAST = sbc_pkg::TMR_W'(FORCE_STEP_CYCLES - 1);

  function automatic sbc_pkg::sbc_sel_t reg_sel(input logic [sbc_pkg::ADDR_W-1:0] a);
    logic [sbc_pkg::ADDR_W-1:0] w;
    w = {a[sbc_pkg::ADDR_W-1:2], 2'h0};
    if (w == sbc_pkg::ADDR_CTRL) return sbc_pkg::SEL_CTRL;
    else if (w == sbc_pkg::ADDR_STATUS) return sbc_pkg::SEL_STATUS;
    else if (w == sbc_pkg::ADDR_PERIOD) return sbc_pkg::SEL_PERIOD;
    else return sbc_pkg::SEL_NONE;
  endfunction

  // high side walks U,V,W forward; stepping backwards gives U,W,V
  function automatic logic [2:0] next_step(input logic [2:0] s, input logic rev);
    if (rev) return (s == sbc_pkg::STEP_FIRST) ? sbc_pkg::STEP_LAST : s - 3'h1; // RQ22
    else return (s == sbc_pkg::STEP_LAST) ? sbc_pkg::STEP_FIRST : s + 3'h1; // RQ22
  endfunction

  function automatic sbc_pkg::sbc_drive_t step_drive(input logic [2:0] s);
    case (s)
      3'h0: return '{hi: 3'h1, lo: 3'h2};
      3'h1: return '{hi: 3'h1, lo: 3'h4};
      3'h2: return '{hi: 3'h2, lo: 3'h4};
      3'h3: return '{hi: 3'h2, lo: 3'h1};
      3'h4: return '{hi: 3'h4, lo: 3'h1};
      3'h5: return '{hi: 3'h4, lo: 3'h2};
      default: return '0;
    endcase
  endfunction

  // a 60 degree interval p gives 30=p/2, 15=p/4, 7.5=p/8
  function automatic logic [sbc_pkg::TMR_W-1:0] lead_time(input logic [sbc_pkg::TMR_W-1:0] p,
                                                         input logic [1:0] lead);
    case (lead)
      sbc_pkg::LEAD_0: return sbc_pkg::TMR_ZERO; // RQ20
      sbc_pkg::LEAD_7P5: return p >> 3; // RQ20
      sbc_pkg::LEAD_15: return p >> 2; // RQ20
      sbc_pkg::LEAD_30: return p >> 1; // RQ20
      default: return sbc_pkg::TMR_ZERO;
    endcase
  endfunction

  // pin inputs, pwm idles high (off)
  logic [2:0] pins_s;
  sbc_sync #(.W(3), .INIT(3'h5)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({overcurrent_in, position_in, pwm_n_in}),
    .dout(pins_s)
  );
  wire pwm_n_s = pins_s[0];
  wire pos_s = pins_s[1]; // RQ3
  wire oc_s = pins_s[2];
  wire pwm_on = ~pwm_n_s; // RQ23

  sbc_pkg::sbc_cfg_t cfg_reg;
  sbc_pkg::sbc_state_t state_reg, state_next;
  logic [2:0] step_reg, step_next;
  logic pwm_n_prev_reg, oc_prev_reg, oc_block_reg;
  logic samp_reg, samp_prev_reg, pos_conf_reg;
  logic [sbc_pkg::WIN_W-1:0] win_cnt_reg;
  logic seen_on_reg, det_prev_reg, run_reg;
  logic [1:0] zc_cnt_reg;
  logic [sbc_pkg::TMR_W-1:0] force_cnt_reg, ivl_cnt_reg, period_reg;
  logic [sbc_pkg::TMR_W-1:0] dly_cnt_reg, ovl_cnt_reg;
  logic dly_arm_reg;
  sbc_pkg::sbc_drive_t prev_drv_reg;
  sbc_pkg::sbc_pins_t pins_reg;

  // edges of the filtered pins
  wire pwm_rise = pwm_n_s & ~pwm_n_prev_reg; // RQ8
  wire pwm_pulse = ~pwm_n_s & pwm_n_prev_reg;
  wire oc_rise = oc_s & ~oc_prev_reg;
  // a new level must be seen at two successive rising edges
  wire zc = pwm_rise & (pos_s == samp_reg) & (samp_reg != pos_conf_reg); // RQ10

  // start/stop window
  wire win_tick = (win_cnt_reg == sbc_pkg::CHECK_LAST);
  wire det = seen_on_reg | pwm_on; // RQ17 RQ18
  wire det_agree = win_tick & (det == det_prev_reg); // RQ19

  // effective lead and commutation timing
  wire lead_30 = (cfg_reg.adv == sbc_pkg::LEAD_30);
  wire [1:0] lead_eff = (state_reg == sbc_pkg::ST_NORMAL) ? cfg_reg.adv : // RQ13
                        (lead_30 ? sbc_pkg::LEAD_30 : sbc_pkg::LEAD_0); // RQ14
  wire [sbc_pkg::TMR_W-1:0] half_ivl = ivl_cnt_reg >> 1;
  wire [sbc_pkg::TMR_W-1:0] lead_amt = lead_time(ivl_cnt_reg, lead_eff);
  wire [sbc_pkg::TMR_W-1:0] dly_load = half_ivl - lead_amt; // RQ5
  // lap stretch: an eighth of the interval plus half the lead
  wire [sbc_pkg::TMR_W-1:0] lap_amt = (period_reg >> 3) + (lead_time(period_reg, cfg_reg.adv) >> 1);
  wire [sbc_pkg::TMR_W-1:0] ovl_load = cfg_reg.lap120 ? sbc_pkg::TMR_ZERO : lap_amt; // RQ15 RQ16
  wire force_step = (state_reg == sbc_pkg::ST_FORCED) & (force_cnt_reg == FORCE_LAST); // RQ6
  wire norm_step = (state_reg == sbc_pkg::ST_NORMAL) & dly_arm_reg & (dly_cnt_reg == sbc_pkg::TMR_ZERO);
  wire commute = force_step | norm_step;
  wire stall = (state_reg == sbc_pkg::ST_NORMAL) & (ivl_cnt_reg == sbc_pkg::TMR_MAX);

  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    case (state_reg)
      sbc_pkg::ST_STOP: begin
        step_next = sbc_pkg::STEP_FIRST; // RQ24
        if (run_reg) state_next = sbc_pkg::ST_FORCED; // RQ4
      end
      sbc_pkg::ST_FORCED: begin
        if (commute) step_next = next_step(step_reg, cfg_reg.rev); // RQ4
        if (zc && (zc_cnt_reg == sbc_pkg::ZC_TO_NORMAL - 2'h1)) state_next = sbc_pkg::ST_NORMAL; // RQ5
      end
      sbc_pkg::ST_NORMAL: begin
        if (commute) step_next = next_step(step_reg, cfg_reg.rev); // RQ5
        // motor lost: fall back to blind stepping
        if (stall) state_next = sbc_pkg::ST_FORCED;
      end
      default: state_next = sbc_pkg::ST_STOP;
    endcase
    if (!run_reg) state_next = sbc_pkg::ST_STOP; // RQ24
  end

  // output shaping
  sbc_pkg::sbc_drive_t cur_drv, raw_drv, drv;
  sbc_pkg::sbc_pins_t pins_next;
  wire chop_lo = cfg_reg.alt & step_reg[0]; // RQ11 RQ21
  wire chop_hi = ~chop_lo; // RQ21
  wire gate = pwm_on & ~oc_block_reg; // RQ7 RQ12
  assign cur_drv = step_drive(step_reg);
  assign raw_drv = (ovl_cnt_reg != sbc_pkg::TMR_ZERO) ? (cur_drv | prev_drv_reg) : cur_drv; // RQ16
  assign drv.hi = raw_drv.hi & {3{~chop_hi | gate}}; // RQ7
  assign drv.lo = raw_drv.lo & {3{~chop_lo | gate}}; // RQ7
  assign pins_next = (state_reg == sbc_pkg::ST_STOP) ? sbc_pkg::PINS_OFF : '{hi_n: ~drv.hi, lo: drv.lo}; // RQ1 RQ2

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= sbc_pkg::ST_STOP;
      step_reg <= sbc_pkg::STEP_FIRST;
      pins_reg <= sbc_pkg::PINS_OFF;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      pins_reg <= pins_next;
    end
  end

  // edge history, position sampling, over-current latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_n_prev_reg <= 1'b1;
      oc_prev_reg <= 1'b1;
      oc_block_reg <= 1'b0;
      samp_reg <= 1'b0;
      samp_prev_reg <= 1'b0;
      pos_conf_reg <= 1'b0;
    end else begin
      pwm_n_prev_reg <= pwm_n_s;
      oc_prev_reg <= oc_s;
      // set wins over the clear at the next pulse
      if (oc_rise) oc_block_reg <= 1'b1; // RQ12
      else if (pwm_pulse) oc_block_reg <= 1'b0; // RQ12
      if (pwm_rise) begin
        samp_reg <= pos_s; // RQ8
        samp_prev_reg <= samp_reg;
      end
      if (zc) pos_conf_reg <= pos_s; // RQ10
    end
  end

  // start/stop detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_cnt_reg <= '0;
      seen_on_reg <= 1'b0;
      det_prev_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      win_cnt_reg <= win_tick ? '0 : win_cnt_reg + 1'b1; // RQ19
      seen_on_reg <= win_tick ? 1'b0 : det;
      if (win_tick) det_prev_reg <= det;
      if (det_agree) run_reg <= det; // RQ17 RQ18 RQ19
    end
  end

  // commutation timers
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg == sbc_pkg::ST_STOP) begin
      zc_cnt_reg <= '0;
      force_cnt_reg <= '0;
      ivl_cnt_reg <= '0;
      period_reg <= '0;
      dly_cnt_reg <= '0;
      dly_arm_reg <= 1'b0;
      ovl_cnt_reg <= '0;
      prev_drv_reg <= '0;
    end else begin
      force_cnt_reg <= force_step ? '0 : force_cnt_reg + 1'b1; // RQ6
      if (zc) begin
        ivl_cnt_reg <= '0;
        period_reg <= ivl_cnt_reg;
        dly_cnt_reg <= dly_load; // RQ13 RQ14
        dly_arm_reg <= 1'b1;
        if (zc_cnt_reg != sbc_pkg::ZC_TO_NORMAL) zc_cnt_reg <= zc_cnt_reg + 2'h1;
      end else begin
        if (ivl_cnt_reg != sbc_pkg::TMR_MAX) ivl_cnt_reg <= ivl_cnt_reg + 1'b1;
        if (dly_cnt_reg != sbc_pkg::TMR_ZERO) dly_cnt_reg <= dly_cnt_reg - 1'b1;
        if (norm_step) dly_arm_reg <= 1'b0;
      end
      if (commute) begin
        prev_drv_reg <= cur_drv;
        ovl_cnt_reg <= norm_step ? ovl_load : sbc_pkg::TMR_ZERO; // RQ15 RQ16
      end else if (ovl_cnt_reg != sbc_pkg::TMR_ZERO) begin
        ovl_cnt_reg <= ovl_cnt_reg - 1'b1;
      end
    end
  end

  assign u_high_side_on_n = pins_reg.hi_n[sbc_pkg::PH_U];
  assign v_high_side_on_n = pins_reg.hi_n[sbc_pkg::PH_V];
  assign w_high_side_on_n = pins_reg.hi_n[sbc_pkg::PH_W];
  assign u_low_side_on = pins_reg.lo[sbc_pkg::PH_U];
  assign v_low_side_on = pins_reg.lo[sbc_pkg::PH_V];
  assign w_low_side_on = pins_reg.lo[sbc_pkg::PH_W];

  // AXI4-Lite slave: address and data latched independently
  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [sbc_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  sbc_pkg::sbc_status_t status;
  assign status = '{lead: lead_eff, oc: oc_block_reg, step: step_reg,
                    normal: (state_reg == sbc_pkg::ST_NORMAL), run: run_reg};
  wire aw_take = s_axi_awvalid & ~aw_full_reg;
  wire w_take = s_axi_wvalid & ~w_full_reg;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire ar_take = s_axi_arvalid & ~rvalid_reg;
  wire sbc_pkg::sbc_sel_t wsel = reg_sel(awaddr_reg);
  wire sbc_pkg::sbc_sel_t rsel = reg_sel(s_axi_araddr);
  logic [31:0] rmux;
  always_comb begin
    case (rsel)
      sbc_pkg::SEL_CTRL: rmux = 32'(cfg_reg);
      sbc_pkg::SEL_STATUS: rmux = 32'(status);
      sbc_pkg::SEL_PERIOD: rmux = 32'(period_reg);
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) wdata_reg <= s_axi_wdata;
      if (w_take) wstrb_reg <= s_axi_wstrb;
      aw_full_reg <= do_write ? 1'b0 : (aw_full_reg | aw_take);
      w_full_reg <= do_write ? 1'b0 : (w_full_reg | w_take);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= sbc_pkg::CTRL_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= sbc_pkg::RESP_OKAY;
    end else begin
      if (do_write && wsel == sbc_pkg::SEL_CTRL && wstrb_reg[0]) cfg_reg <= wdata_reg[sbc_pkg::CTRL_W-1:0];
      if (do_write) bresp_reg <= (wsel == sbc_pkg::SEL_NONE) ? sbc_pkg::RESP_SLVERR : sbc_pkg::RESP_OKAY;
      bvalid_reg <= do_write | (bvalid_reg & ~s_axi_bready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= sbc_pkg::RESP_OKAY;
    end else begin
      if (ar_take) rdata_reg <= rmux;
      if (ar_take) rresp_reg <= (rsel == sbc_pkg::SEL_NONE) ? sbc_pkg::RESP_SLVERR : sbc_pkg::RESP_OKAY;
      rvalid_reg <= ar_take | (rvalid_reg & ~s_axi_rready);
    end
  end

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready = ~w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stop_all_off: assert property (state_reg == sbc_pkg::ST_STOP |=> pins_reg == sbc_pkg::PINS_OFF) // RQ24
    else $error("outputs not off while stopped");
  a_no_shoot_through: assert property ((~pins_reg.hi_n & pins_reg.lo) == 3'h0) // RQ1
    else $error("upper and lower switch of one phase both on");
  a_sample_on_rise: assert property ($changed(samp_reg) |-> $past(pwm_rise)) // RQ8
    else $error("position sampled off a pwm rising edge");
  a_confirm_twice: assert property (zc |=> pos_conf_reg == samp_reg && samp_prev_reg == samp_reg) // RQ10
    else $error("position change taken on a single sample");
  a_forced_step_time: assert property (force_step && run_reg |=> step_reg != $past(step_reg)) // RQ6
    else $error("forced step missed its period");
  a_pwm_gates_upper: assert property (!pwm_on && !cfg_reg.alt ##1 !pwm_on |-> pins_reg.hi_n == 3'h7) // RQ7
    else $error("upper switch on during pwm off time");
  a_oc_cuts_upper: assert property (oc_rise && !cfg_reg.alt |=> ##1 pins_reg.hi_n == 3'h7) // RQ12
    else $error("over-current did not cut the chopped switch");
  a_normal_entry: assert property ($rose(state_reg == sbc_pkg::ST_NORMAL) |-> $past(zc)) // RQ5
    else $error("normal commutation entered without a position edge");
  a_forced_lead: assert property (state_reg != sbc_pkg::ST_NORMAL && !lead_30 |-> lead_eff == sbc_pkg::LEAD_0) // RQ13
    else $error("nonzero lead outside normal commutation");
  a_run_two_checks: assert property ($changed(run_reg) |-> $past(win_tick) && $past(det) == $past(det_prev_reg)) // RQ19
    else $error("run state changed without two agreeing checks");

  c_go_normal: cover property (state_reg == sbc_pkg::ST_FORCED ##1 state_reg == sbc_pkg::ST_NORMAL);
  c_oc_event: cover property (oc_rise ##[1:200] pwm_pulse);
  c_ctrl_write: cover property (do_write && wsel == sbc_pkg::SEL_CTRL);
  c_stop_after_run: cover property ($fell(run_reg));
endmodule

/* sim/sbc_motor_model.sv */
// power stage and pwm source stand-in for the commutation block
`timescale 1ns/1ps
module sbc_motor_model #(
  parameter int PWM_PER = 40,
  parameter int PWM_ON = 30,
  parameter int POS_HALF = 800
) (
  input wire logic aclk,
  input wire logic pwm_en,
  input wire logic pos_en,
  input wire logic oc_req,
  output logic pwm_n_in,
  output logic position_in,
  output logic overcurrent_in
);
  int pcnt = 0;
  int qcnt = 0;
  initial begin
    pwm_n_in = 1'b1;
    position_in = 1'b0;
    overcurrent_in = 1'b0;
  end
  always @(posedge aclk) begin
    pcnt <= (pcnt == PWM_PER - 1) ? 0 : pcnt + 1;
    // active low, never stuck low; idles at the pull-up level when off
    pwm_n_in <= !(pwm_en && pcnt < PWM_ON);
    overcurrent_in <= oc_req;
    if (pos_en) begin
      qcnt <= (qcnt == POS_HALF - 1) ? 0 : qcnt + 1;
      // majority comparator output flips once per sixty electrical degrees, one commutation step
      if (qcnt == POS_HALF - 1) position_in <= !position_in;
    end
  end
endmodule

/* sim/tb_top.sv */
// self-checking bench for the sensorless commutation block
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, pwm_en = 1'b1, pos_en = 1'b0, oc_req = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pwm_n_in, position_in, overcurrent_in;
  logic [2:0] hi_n, lo, prev;
  logic [4:0] cfg;
  int errors = 0, total_checks = 0, cyc = 0;
  logic [31:0] rexp_q[$], rmask_q[$];
  logic [1:0] rresp_q[$], bresp_q[$];

  sbc_top #(.FORCE_STEP_CYCLES(64)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pwm_n_in, .position_in, .overcurrent_in, .u_high_side_on_n(hi_n[0]), .u_low_side_on(lo[0]),
    .v_high_side_on_n(hi_n[1]), .v_low_side_on(lo[1]), .w_high_side_on_n(hi_n[2]), .w_low_side_on(lo[2]));
  sbc_motor_model mdl (.aclk, .pwm_en, .pos_en, .oc_req, .pwm_n_in, .position_in, .overcurrent_in);

  initial begin
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;

  task chk(string n, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
    bresp_q.push_back(er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask

  task rd(logic [3:0] a, logic [31:0] e, logic [31:0] m, logic [1:0] er);
    rexp_q.push_back(e & m);
    rmask_q.push_back(m);
    rresp_q.push_back(er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask

  // answers are judged against the oldest note, in issue order
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rexp_q.size() > 0) begin
      chk("rdata", s_axi_rdata & rmask_q.pop_front(), rexp_q.pop_front());
      chk("rresp", 32'(s_axi_rresp), 32'(rresp_q.pop_front()));
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && bresp_q.size() > 0)
      chk("bresp", 32'(s_axi_bresp), 32'(bresp_q.pop_front()));
  end

  // stop needs two silent windows, up to three window lengths
  task stop_motor;
    pwm_en <= 1'b0;
    repeat (1700) @(posedge aclk);
    chk("pins off", 32'({hi_n, lo}), 32'h38);
    rd(4'h4, 32'h0, 32'h3, sbc_pkg::RESP_OKAY);
    prev = 3'h0;
  endtask

  task low_step(logic [2:0] e);
    for (int n = 0; n < 3000 && (lo === prev || lo === 3'h0); n++) @(posedge aclk);
    chk("low side", 32'(lo), 32'(e));
    prev = lo;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    void'($urandom(32'h42b1));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0, 32'h10, 32'hFFFFFFFF, sbc_pkg::RESP_OKAY);
    rd(4'hC, 32'h0, 32'hFFFFFFFF, sbc_pkg::RESP_SLVERR);
    wr(4'hC, 32'h1F, sbc_pkg::RESP_SLVERR);
    wr(4'h4, 32'hFF, sbc_pkg::RESP_OKAY);
    cfg = 5'($urandom);
    wr(4'h0, {27'h0, cfg}, sbc_pkg::RESP_OKAY);
    rd(4'h0, {27'h0, cfg}, 32'hFFFFFFFF, sbc_pkg::RESP_OKAY);
    $display("test registers done");
    wait (cyc >= 600);
    rd(4'h4, 32'h0, 32'h1, sbc_pkg::RESP_OKAY);
    wait (cyc >= 1150);
    rd(4'h4, 32'h1, 32'h1, sbc_pkg::RESP_OKAY);
    $display("test start detect done");
    for (int d = 0; d < 2; d++) begin
      stop_motor();
      cfg = {2'b10, 1'(d), 2'b00};
      wr(4'h0, {27'h0, cfg}, sbc_pkg::RESP_OKAY);
      pwm_en <= 1'b1;
      low_step(3'b010);
      low_step(d ? 3'b001 : 3'b100);
      low_step(d ? 3'b100 : 3'b001);
      // raise over-current early in an on pulse so the cut is seen before the pulse ends
      @(posedge aclk iff mdl.pcnt == 2);
      oc_req <= 1'b1;
      repeat (12) @(posedge aclk);
      chk("oc cut", 32'(hi_n), 32'h7);
      oc_req <= 1'b0;
      repeat (40) @(posedge aclk);
      chk("oc resume", 32'(hi_n == 3'h7), 32'h0);
      $display("test direction %0d done", d);
    end
    for (int a = 0; a < 4; a++) begin
      stop_motor();
      cfg = {2'($urandom), 1'($urandom), 2'(a)};
      wr(4'h0, {27'h0, cfg}, sbc_pkg::RESP_OKAY);
      pwm_en <= 1'b1;
      repeat (1150) @(posedge aclk);
      rd(4'h4, {24'h0, (a == 3) ? 2'h3 : 2'h0, 6'h1}, 32'hC3, sbc_pkg::RESP_OKAY);
      pos_en <= 1'b1;
      repeat (3000) @(posedge aclk);
      rd(4'h4, {24'h0, 2'(a), 6'h3}, 32'hC3, sbc_pkg::RESP_OKAY);
      pos_en <= 1'b0;
      $display("test lead %0d done", a);
    end
    stop_motor();
    finish_test();
  end
endmodule
